// ==== dpc_pkg.sv ====
// constants for the memory power-up and access controller
package dpc_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PS = 8000;
    localparam int T_RESET_US = 200;             // reset low pulse, plain default
    localparam int T_TEN_US = 700;
    localparam int T_CKE_RST_NS = 10;
    localparam int T_INIT_US = 500;
    localparam int T_CLK_STABLE_NS = 10;
    localparam int T_CLK_STABLE_TCK = 5;
    localparam int T_XPR_CYC = 64;               // plain default
    localparam int T_MRD_CYC = 8;
    localparam int T_MOD_CYC = 24;
    localparam int T_ZQINIT_CYC = 1024;
    localparam int T_DLLK_CYC = 1024;
    localparam int T_RP_CYC = 14;
    localparam int T_RCD_CYC = 14;
    localparam int T_BURST_CYC = 4;
    localparam int RESET_CYC = (T_RESET_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int TEN_CYC = (T_TEN_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int CKE_RST_CYC = (T_CKE_RST_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INIT_CYC = (T_INIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int CLKSTB_NS_CYC = (T_CLK_STABLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CLKSTB_CYC = CLKSTB_NS_CYC > T_CLK_STABLE_TCK ? CLKSTB_NS_CYC : T_CLK_STABLE_TCK;
    localparam int ZQDLL_CYC = T_ZQINIT_CYC > T_DLLK_CYC ? T_ZQINIT_CYC : T_DLLK_CYC;
    // ------------------------------------------------------------
    // command encoding {act_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_DES = 4'hf;
    localparam logic [3:0] CMD_MRS = 4'h8;
    localparam logic [3:0] CMD_PRE = 4'ha;
    localparam logic [3:0] CMD_WR = 4'hc;
    localparam logic [3:0] CMD_RD = 4'hd;
    localparam logic [3:0] CMD_ZQ = 4'he;
    localparam logic [3:0] CMD_ACT = 4'h0;
    // ------------------------------------------------------------
    // address fields
    // ------------------------------------------------------------
    localparam int A_AP = 10;
    localparam int A_BC = 12;
    localparam int MR3_GEARDOWN = 3;
    localparam int MR3_PDA = 4;
    localparam int MR4_MPSM = 1;
    localparam int MR4_SPPR = 5;
    localparam int MR4_CAL_LO = 6;
    localparam int MR4_HPPR = 13;
    localparam int NUM_BANKS = 16;
    localparam int NUM_MRS = 7;
    localparam int MRS_WAIT_CYC = T_MRD_CYC;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_CKE_LOW = 4'h1, ST_WAIT_INIT = 4'h2, ST_XPR = 4'h3,
        ST_MRS = 4'h4, ST_MRS_WAIT = 4'h5, ST_ZQ = 4'h6, ST_ZQ_WAIT = 4'h7,
        ST_IDLE = 4'h8, ST_PRE = 4'h9, ST_ACT = 4'ha, ST_RW = 4'hb, ST_WAIT = 4'hc
    } dpc_state_t;
endpackage

// ==== dpc_ctrl.sv ====
// power-up sequencer and row/column access controller for a ddr4 device
`timescale 1ns/1ps
// How it works
// - bursts of eight or chopped four from selected column
// - activate a row before reading or writing that bank
// - nop only for power-saving exit or gear-down entry
// - hold reset and test-enable low while supplies ramp
// - hold reset low for minimum pulse after power stable
// - hold test-enable low at least 700 us
// - drive cke low 10 ns before reset release
// - release reset within 10 minutes of stable supply
// - start initialization within 3 seconds of reset release
// - debug mode may extend both limits to 60 minutes
// - wait 500 us to 3 s after reset before cke high
// - clock stable 5 cycles, deselect on cke edge
// - program mr3, mr6, mr5, mr4, mr2, mr1, mr0 with waits
// - issue long zq calibration, wait dll lock and zq init
module dpc_ctrl #(
    parameter int RESET_CYC = dpc_pkg::RESET_CYC,
    parameter int TEN_CYC = dpc_pkg::TEN_CYC,
    parameter int INIT_CYC = dpc_pkg::INIT_CYC,
    parameter int ROW_W = 18,
    parameter int COL_W = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // power good from the supply monitor
    input wire logic pwr_ok,
    // user request port
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_chop,
    input wire logic req_autopre,
    input wire logic [1:0] req_bg,
    input wire logic [1:0] req_ba,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    output logic req_ready,
    output logic init_done,
    // mode register contents to program, mr0..mr6
    input wire logic [17:0] mr_val [dpc_pkg::NUM_MRS],
    // device pins
    output logic mem_reset_n,
    output logic mem_ten,
    output logic mem_cke,
    output logic mem_cs_n,
    output logic mem_act_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [1:0] mem_bg,
    output logic [1:0] mem_ba,
    output logic [17:0] mem_addr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dpc_pkg::dpc_state_t st_q, nxt_q;
    logic [31:0] cnt_q;
    logic [2:0] mrs_idx_q;
    logic pwr_s1_q, pwr_s2_q;
    localparam int NUM_BANKS_W = 4;
    logic [NUM_BANKS_W-1:0] bank_sel;
    logic [2:0] mrs_sel;
    logic [dpc_pkg::NUM_BANKS-1:0] open_q;
    logic [ROW_W-1:0] row_q [dpc_pkg::NUM_BANKS];
    logic lat_write_q, lat_chop_q, lat_ap_q;
    logic [1:0] lat_bg_q, lat_ba_q;
    logic [ROW_W-1:0] lat_row_q;
    logic [COL_W-1:0] lat_col_q;
    logic [NUM_BANKS_W-1:0] lat_bank_q;

    // mode register order: mr3, mr6, mr5, mr4, mr2, mr1, mr0
    function automatic logic [2:0] mrs_num(input logic [2:0] idx);
        logic [2:0] r;
        r = 3'h0;
        unique case (idx)
            3'h0: r = 3'h3;
            3'h1: r = 3'h6;
            3'h2: r = 3'h5;
            3'h3: r = 3'h4;
            3'h4: r = 3'h2;
            3'h5: r = 3'h1;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // command pins from a 4-bit code, chip selected for all but deselect
    task automatic drive_cmd(input logic [3:0] c);
        mem_cs_n <= (c == dpc_pkg::CMD_DES);
        {mem_act_n, mem_ras_n, mem_cas_n, mem_we_n} <= c;
    endtask

    // ------------------------------------------------------------
    // power-good synchroniser, it comes from outside the clock domain
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
        end else begin
            pwr_s1_q <= pwr_ok;
            pwr_s2_q <= pwr_s1_q;
        end
    end

    // bank index of the request and mode register number being loaded
    assign bank_sel = {req_bg, req_ba};
    assign mrs_sel = mrs_num(mrs_idx_q);

    // ------------------------------------------------------------
    // sequencer: power-up, mode registers, calibration, accesses
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= dpc_pkg::ST_RESET;
            nxt_q <= dpc_pkg::ST_IDLE;
            cnt_q <= 32'h0;
            mrs_idx_q <= 3'h0;
            mem_reset_n <= 1'b0;
            mem_ten <= 1'b0;
            mem_cke <= 1'b0;
            mem_cs_n <= 1'b1;
            {mem_act_n, mem_ras_n, mem_cas_n, mem_we_n} <= dpc_pkg::CMD_DES;
            mem_bg <= 2'h0;
            mem_ba <= 2'h0;
            mem_addr <= 18'h0;
            req_ready <= 1'b0;
            init_done <= 1'b0;
            open_q <= '0;
            lat_write_q <= 1'b0;
            lat_chop_q <= 1'b0;
            lat_ap_q <= 1'b0;
            lat_bg_q <= 2'h0;
            lat_ba_q <= 2'h0;
            lat_row_q <= '0;
            lat_col_q <= '0;
            lat_bank_q <= '0;
        end else begin
            // deselect unless a state issues a command; nop never used
            // no nop issued
            drive_cmd(dpc_pkg::CMD_DES);
            req_ready <= 1'b0;
            cnt_q <= cnt_q + 32'h1;
            unique case (st_q)
                dpc_pkg::ST_RESET: begin
                    if (!pwr_s2_q) begin
                        cnt_q <= 32'h0;
                    end else if (cnt_q >= 32'(RESET_CYC) && cnt_q >= 32'(TEN_CYC)
                                 && cnt_q >= 32'(dpc_pkg::CKE_RST_CYC)) begin
                        mem_reset_n <= 1'b1;
                        cnt_q <= 32'h0;
                        st_q <= dpc_pkg::ST_WAIT_INIT;
                    end
                end
                dpc_pkg::ST_WAIT_INIT: begin
                    if (cnt_q >= 32'(INIT_CYC) && cnt_q >= 32'(dpc_pkg::CLKSTB_CYC)) begin
                        mem_cke <= 1'b1;
                        cnt_q <= 32'h0;
                        st_q <= dpc_pkg::ST_XPR;
                    end
                end
                dpc_pkg::ST_XPR: begin
                    if (cnt_q >= 32'(dpc_pkg::T_XPR_CYC)) begin
                        st_q <= dpc_pkg::ST_MRS;
                    end
                end
                dpc_pkg::ST_MRS: begin
                    drive_cmd(dpc_pkg::CMD_MRS);
                    mem_bg <= {1'b0, mrs_sel[2]};
                    mem_ba <= mrs_sel[1:0];
                    mem_addr <= mr_val[mrs_sel];
                    cnt_q <= 32'h0;
                    st_q <= dpc_pkg::ST_MRS_WAIT;
                end
                dpc_pkg::ST_MRS_WAIT: begin
                    // mr0 is last and needs the longer update delay
                    if (mrs_idx_q == 3'(dpc_pkg::NUM_MRS - 1)) begin
                        if (cnt_q >= 32'(dpc_pkg::T_MOD_CYC)) begin
                            st_q <= dpc_pkg::ST_ZQ;
                        end
                    end else if (cnt_q >= 32'(dpc_pkg::MRS_WAIT_CYC)) begin
                        mrs_idx_q <= mrs_idx_q + 3'h1;
                        st_q <= dpc_pkg::ST_MRS;
                    end
                end
                dpc_pkg::ST_ZQ: begin
                    drive_cmd(dpc_pkg::CMD_ZQ);
                    mem_addr <= 18'h0;
                    mem_addr[dpc_pkg::A_AP] <= 1'b1;
                    cnt_q <= 32'h0;
                    st_q <= dpc_pkg::ST_ZQ_WAIT;
                end
                dpc_pkg::ST_ZQ_WAIT: begin
                    if (cnt_q >= 32'(dpc_pkg::ZQDLL_CYC)) begin
                        init_done <= 1'b1;
                        req_ready <= 1'b1;
                        st_q <= dpc_pkg::ST_IDLE;
                    end
                end
                dpc_pkg::ST_IDLE: begin
                    req_ready <= !req_valid;
                    if (req_valid) begin
                        lat_write_q <= req_write;
                        lat_chop_q <= req_chop;
                        lat_ap_q <= req_autopre;
                        lat_bg_q <= req_bg;
                        lat_ba_q <= req_ba;
                        lat_row_q <= req_row;
                        lat_col_q <= req_col;
                        lat_bank_q <= bank_sel;
                        if (open_q[bank_sel] && row_q[bank_sel] == req_row) begin
                            st_q <= dpc_pkg::ST_RW;
                        end else if (open_q[bank_sel]) begin
                            st_q <= dpc_pkg::ST_PRE;
                        end else begin
                            st_q <= dpc_pkg::ST_ACT;
                        end
                    end
                end
                dpc_pkg::ST_PRE: begin
                    drive_cmd(dpc_pkg::CMD_PRE);
                    mem_bg <= lat_bg_q;
                    mem_ba <= lat_ba_q;
                    mem_addr <= 18'h0;
                    open_q[lat_bank_q] <= 1'b0;
                    cnt_q <= 32'(dpc_pkg::T_BURST_CYC) - 32'(dpc_pkg::T_RP_CYC);
                    nxt_q <= dpc_pkg::ST_ACT;
                    st_q <= dpc_pkg::ST_WAIT;
                end
                dpc_pkg::ST_ACT: begin
                    drive_cmd(dpc_pkg::CMD_ACT);
                    mem_bg <= lat_bg_q;
                    mem_ba <= lat_ba_q;
                    mem_addr <= 18'(lat_row_q);
                    open_q[lat_bank_q] <= 1'b1;
                    cnt_q <= 32'(dpc_pkg::T_BURST_CYC) - 32'(dpc_pkg::T_RCD_CYC);
                    nxt_q <= dpc_pkg::ST_RW;
                    st_q <= dpc_pkg::ST_WAIT;
                end
                dpc_pkg::ST_RW: begin
                    // bl8 or bc4 on the fly
                    drive_cmd(lat_write_q ? dpc_pkg::CMD_WR : dpc_pkg::CMD_RD);
                    mem_bg <= lat_bg_q;
                    mem_ba <= lat_ba_q;
                    mem_addr <= 18'(lat_col_q);
                    mem_addr[dpc_pkg::A_AP] <= lat_ap_q;
                    mem_addr[dpc_pkg::A_BC] <= !lat_chop_q;
                    if (lat_ap_q) begin
                        open_q[lat_bank_q] <= 1'b0;
                    end
                    cnt_q <= 32'h0;
                    nxt_q <= dpc_pkg::ST_IDLE;
                    st_q <= dpc_pkg::ST_WAIT;
                end
                dpc_pkg::ST_WAIT: begin
                    // counter preloaded negative after precharge or activate, zero after an access, so all waits end at burst length;
                    // the issuing state chose the follower, so a row miss never ends early
                    if (cnt_q == 32'(dpc_pkg::T_BURST_CYC)) begin
                        req_ready <= (nxt_q == dpc_pkg::ST_IDLE);
                        st_q <= nxt_q;
                    end
                end
                default: st_q <= dpc_pkg::ST_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // open-row table
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (st_q == dpc_pkg::ST_ACT) begin
            row_q[lat_bank_q] <= lat_row_q;
        end
    end
endmodule

// ==== dpc_ctrl_props.sv ====
// concurrent checks on the controller pins
`timescale 1ns/1ps
module dpc_ctrl_props #(
    parameter int RESET_CYC = 8,
    parameter int INIT_CYC = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // status
    input wire logic pwr_ok,
    input wire logic init_done,
    // device pins
    input wire logic mem_reset_n,
    input wire logic mem_ten,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_act_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [1:0] mem_bg,
    input wire logic [1:0] mem_ba,
    input wire logic [17:0] mem_addr
);
    logic [3:0] cmd;
    logic [3:0] bk;
    logic is_act;
    logic is_rw;
    logic [15:0] open_q;
    logic [15:0] rcnt_q;
    logic [15:0] icnt_q;
    logic [15:0] zcnt_q;
    assign cmd = {mem_act_n, mem_ras_n, mem_cas_n, mem_we_n};
    assign bk = {mem_bg, mem_ba};
    assign is_act = !mem_cs_n && !mem_act_n;
    assign is_rw = !mem_cs_n && mem_act_n && cmd[3:1] == 3'h6;
    // open banks; auto-precharge closes the bank at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            open_q <= 16'h0000;
        end else if (is_act) begin
            open_q[bk] <= 1'b1;
        end else if (!mem_cs_n && cmd == dpc_pkg::CMD_PRE) begin
            open_q <= mem_addr[10] ? 16'h0000 : open_q & ~(16'h0001 << bk);
        end else if (is_rw && mem_addr[10]) begin
            open_q[bk] <= 1'b0;
        end
    end
    // saturating timers, so long waits never wrap into a false failure
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= 16'h0000;
            icnt_q <= 16'h0000;
            zcnt_q <= 16'h0000;
        end else begin
            if (!mem_reset_n && pwr_ok && !(&rcnt_q)) rcnt_q <= rcnt_q + 16'h0001;
            if (mem_reset_n && !mem_cke && !(&icnt_q)) icnt_q <= icnt_q + 16'h0001;
            if (!mem_cs_n && cmd == dpc_pkg::CMD_ZQ) zcnt_q <= 16'h0001;
            else if (zcnt_q != 16'h0000 && !(&zcnt_q)) zcnt_q <= zcnt_q + 16'h0001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ten_held_low: assert property (!mem_ten)
        else $error("test enable raised");
    a_cke_before_release: assert property ($rose(mem_reset_n) |-> !$past(mem_cke) && !$past(mem_cke, 2))
        else $error("cke not low ahead of reset release");
    a_reset_low_width: assert property ($rose(mem_reset_n) |-> rcnt_q >= RESET_CYC)
        else $error("reset released too early");
    a_init_wait: assert property ($rose(mem_cke) |-> icnt_q >= INIT_CYC)
        else $error("cke raised too soon after reset");
    a_deselect_on_cke: assert property ($rose(mem_cke) |-> mem_cs_n [*5])
        else $error("command on the cke edge");
    a_cke_stays_high: assert property (mem_reset_n && $past(mem_cke) |-> mem_cke)
        else $error("cke dropped during operation");
    a_no_nop_cmd: assert property (!mem_cs_n |-> cmd != dpc_pkg::CMD_DES)
        else $error("no-op command issued");
    a_access_open_row: assert property (is_rw |-> open_q[bk])
        else $error("access to a closed bank");
    a_act_closed_bank: assert property (is_act |-> !open_q[bk])
        else $error("activate on an open bank");
    a_zq_wait_done: assert property ($rose(init_done) |-> zcnt_q >= dpc_pkg::ZQDLL_CYC)
        else $error("init done before calibration wait");
    c_init: cover property ($rose(init_done));
    c_autopre: cover property (is_rw && mem_addr[10]);
    c_precharge: cover property (!mem_cs_n && cmd == dpc_pkg::CMD_PRE);
    c_activate: cover property (is_act);
endmodule
bind dpc_ctrl dpc_ctrl_props #(.RESET_CYC(RESET_CYC), .INIT_CYC(INIT_CYC)) u_props (
    .mclk, .rst_n, .pwr_ok, .init_done, .mem_reset_n, .mem_ten, .mem_cke, .mem_cs_n,
    .mem_act_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_bg, .mem_ba, .mem_addr);

// ==== dpc_dev_model.sv ====
// behavioural memory device seen at its command pins
`timescale 1ns/1ps
module dpc_dev_model (
    // clock
    input wire logic mclk,
    // device pins
    input wire logic mem_reset_n,
    input wire logic mem_ten,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_act_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [1:0] mem_bg,
    input wire logic [1:0] mem_ba,
    input wire logic [17:0] mem_addr
);
    // load order 3,6,5,4,2,1,0, three bits each from the bottom
    localparam logic [20:0] MR_ORDER = 21'h0a973;
    logic [17:0] mr_q [7];
    logic [15:0] open_q;
    logic [3:0] bank;
    logic [3:0] last_bank;
    logic [17:0] last_row;
    logic [9:0] last_col;
    logic last_ap, last_bc, last_wr, test_mode;
    int mr_idx;
    int viol = 0, n_act = 0, n_pre = 0, n_rw = 0;
    assign bank = {mem_bg, mem_ba};
    assign test_mode = mem_ten;
    always @(posedge mclk or negedge mem_reset_n) begin
        if (!mem_reset_n) begin
            for (int i = 0; i < 7; i++) mr_q[i] <= 18'h00000;
            open_q <= 16'h0000;
            mr_idx <= 0;
        end else if (test_mode) begin
            // connectivity test is never wanted in operation
            viol <= viol + 1;
        end else casez ({mem_cke & ~mem_cs_n, mem_act_n, mem_ras_n, mem_cas_n, mem_we_n})
            // a row opens only in a closed bank
            5'b10???: begin
                viol <= viol + int'(open_q[bank]);
                open_q[bank] <= 1'b1;
                {last_bank, last_row} <= {bank, mem_addr};
                n_act <= n_act + 1;
            end
            // mode registers land in the fixed order
            {1'b1, dpc_pkg::CMD_MRS}: begin
                viol <= viol + int'(mr_idx > 6 || {mem_bg[0], mem_ba} != MR_ORDER[mr_idx*3 +: 3]);
                mr_q[{mem_bg[0], mem_ba}] <= mem_addr;
                mr_idx <= mr_idx + 1;
            end
            {1'b1, dpc_pkg::CMD_PRE}: begin
                open_q <= mem_addr[10] ? 16'h0000 : open_q & ~(16'h0001 << bank);
                n_pre <= n_pre + 1;
            end
            // open row, start column, a10 and a12
            {1'b1, dpc_pkg::CMD_RD}, {1'b1, dpc_pkg::CMD_WR}: begin
                viol <= viol + int'(!open_q[bank]);
                if (mem_addr[10]) open_q[bank] <= 1'b0;
                {last_wr, last_ap, last_bc, last_col} <= {!mem_we_n, mem_addr[10], mem_addr[12], mem_addr[9:0]};
                n_rw <= n_rw + 1;
            end
            // a no-op on the bus is never expected
            {1'b1, dpc_pkg::CMD_DES}: viol <= viol + 1;
            default: ;
        endcase
    end
endmodule

// ==== dpc_ctrl_test.sv ====
// self-checking bench for the power-up and access controller
`timescale 1ns/1ps
module dpc_ctrl_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr_ok = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0, req_chop = 1'b0, req_autopre = 1'b0;
    logic [1:0] req_bg = 2'h0, req_ba = 2'h0;
    logic [17:0] req_row = 18'h00000;
    logic [9:0] req_col = 10'h000;
    logic [17:0] mr_val [7];
    logic req_ready, init_done, mem_reset_n, mem_ten, mem_cke, mem_cs_n;
    logic mem_act_n, mem_ras_n, mem_cas_n, mem_we_n;
    logic [1:0] mem_bg, mem_ba;
    logic [17:0] mem_addr;
    int n_errors = 0;
    int num_checks = 0;
    // 8 ns clock
    always #4 mclk = ~mclk;
    dpc_ctrl #(.RESET_CYC(8), .TEN_CYC(8), .INIT_CYC(8)) dut_u (
        .mclk, .rst_n, .pwr_ok, .req_valid, .req_write, .req_chop, .req_autopre, .req_bg, .req_ba,
        .req_row, .req_col, .req_ready, .init_done, .mr_val, .mem_reset_n, .mem_ten, .mem_cke,
        .mem_cs_n, .mem_act_n, .mem_ras_n, .mem_cas_n, .mem_we_n, .mem_bg, .mem_ba, .mem_addr);
    dpc_dev_model dev_u (
        .mclk, .mem_reset_n, .mem_ten, .mem_cke, .mem_cs_n, .mem_act_n, .mem_ras_n, .mem_cas_n,
        .mem_we_n, .mem_bg, .mem_ba, .mem_addr);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // pins parked while held in reset
    task automatic t_reset_pins;
        repeat (2) @(posedge mclk);
        #1;
        check({mem_reset_n, mem_ten, mem_cke, mem_cs_n}, 1);
    endtask
    // power comes good late; requests before init must be ignored
    task automatic t_init;
        int k;
        int r0;
        r0 = dev_u.n_rw;
        repeat (4) @(posedge mclk);
        #1;
        check(mem_reset_n, 0);
        pwr_ok = 1'b1;
        req_valid = 1'b1;
        repeat (6) @(posedge mclk);
        #1 req_valid = 1'b0;
        for (k = 0; init_done !== 1'b1 && k < 4000; k++) @(posedge mclk);
        #1;
        check(init_done, 1);
        check(dev_u.n_rw, r0);
        for (int i = 0; i < 7; i++) check(dev_u.mr_q[i], mr_val[i]);
    endtask
    // one request; fields stay put until completion, then pins are judged
    task automatic do_access(input logic [2:0] wca, input logic [3:0] bank, input logic [17:0] row,
            input logic [9:0] col, input int da, input int dp);
        int a0, p0, r0, k;
        logic rdy;
        @(posedge mclk);
        #1;
        a0 = dev_u.n_act;
        p0 = dev_u.n_pre;
        r0 = dev_u.n_rw;
        {req_write, req_chop, req_autopre} = wca;
        {req_bg, req_ba} = bank;
        req_row = row;
        req_col = col;
        req_valid = 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            rdy = req_ready;
            @(posedge mclk);
            k++;
        end while (rdy !== 1'b1 && k < 100);
        #1 req_valid = 1'b0;
        for (; dev_u.n_rw == r0 && k < 100; k++) @(posedge mclk);
        rdy = 1'b0;
        for (; rdy !== 1'b1 && k < 100; k++) begin
            @(negedge mclk);
            rdy = req_ready;
        end
        check(rdy, 1);
        check(dev_u.n_act - a0, da);
        check(dev_u.n_pre - p0, dp);
        check({dev_u.last_bank, dev_u.last_row}, {bank, row});
        check({dev_u.last_wr, dev_u.last_ap, dev_u.last_col}, {wca[2], wca[0], col});
        check(dev_u.last_bc, !wca[1]);
    endtask
    // first write opens the top row of the last bank
    task automatic t_open_write;
        do_access(3'h4, 4'hf, 18'h3ffff, 10'h3ff, 1, 0);
    endtask
    // chopped read of the open row: no precharge, no activate
    task automatic t_hit_chop;
        do_access(3'h2, 4'hf, 18'h3ffff, 10'h000, 0, 0);
    endtask
    // another row in an open bank needs a precharge first
    task automatic t_row_miss;
        do_access(3'h0, 4'hf, 18'h00000, 10'h155, 1, 1);
    endtask
    // auto-precharge closes the bank, so the same row reopens
    task automatic t_autopre;
        do_access(3'h5, 4'h1, 18'h2aaaa, 10'h2aa, 1, 0);
        do_access(3'h0, 4'h1, 18'h2aaaa, 10'h001, 1, 0);
    endtask
    // every bank group once, each closed again by auto-precharge
    task automatic t_all_groups;
        for (int g = 0; g < 4; g++) do_access(3'h1, {g[1:0], 2'h2}, 18'(g), 10'(g * 8), 1, 0);
    endtask
    // reset in mid-run: pins park, start-up repeats, banks are forgotten
    task automatic t_rerun;
        @(posedge mclk);
        #1 rst_n = 1'b0;
        t_reset_pins;
        @(posedge mclk);
        #1 rst_n = 1'b1;
        t_init;
        t_open_write;
    endtask
    initial begin
        for (int i = 0; i < 7; i++) mr_val[i] = 18'h15000 | 18'(i);
        t_reset_pins;
        @(posedge mclk);
        #1 rst_n = 1'b1;
        t_init;
        t_open_write;
        t_hit_chop;
        t_row_miss;
        t_autopre;
        t_all_groups;
        t_rerun;
        check(dev_u.viol, 0);
        report_and_stop;
    end
    // hang guard: the full run needs about 2700 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        report_and_stop;
    end
endmodule
